// ==== pkg/vdte_pkg.sv ====
// shared types and constants for the vlan double tag engine
package vdte_pkg;
   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int NUM_PORTS = 8;
   localparam int PORT_W = 3;
   localparam int TPID_ENTRIES = 6;
   localparam int PCFG_W = 20;

   // ****************************************************************
   // tag values
   // ****************************************************************
   localparam logic [15:0] TPID_DOT1Q = 16'h8100;
   localparam logic [15:0] TPID_RST = 16'h8100;

   // ****************************************************************
   // frame byte positions (count of bytes already taken)
   // ****************************************************************
   localparam logic [15:0] IDX_FIRST = 16'h0000;
   localparam logic [15:0] IDX_TYPE_HI = 16'h000C;
   localparam logic [15:0] IDX_TYPE_LO = 16'h000D;
   localparam logic [15:0] IDX_TCI_HI = 16'h000E;
   localparam logic [15:0] IDX_TCI_LO = 16'h000F;
   localparam logic [15:0] IDX_TYPE2_HI = 16'h0010;
   localparam logic [15:0] IDX_TYPE2_LO = 16'h0011;
   // pops of the original tag happen while the count is in this range
   localparam logic [15:0] IDX_DROP_LO = 16'h0010;
   localparam logic [15:0] IDX_DROP_HI = 16'h0013;
   localparam logic [2:0] DLY_DEPTH = 3'h4;
   localparam logic [1:0] LAST_BYTE = 2'h3;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ABORTS = 8'h04;
   localparam logic [7:0] REG_TPID_BASE = 8'h10;
   localparam logic [7:0] REG_PORT_BASE = 8'h40;
   localparam int CTRL_EN_BIT = 0;

   // ****************************************************************
   // frame check sequence
   // ****************************************************************
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_XOR_OUT = 32'hFFFFFFFF;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      ROLE_NORMAL = 2'b00,
      ROLE_ACCESS = 2'b01,
      ROLE_TUNNEL = 2'b10
   } vdte_role_type;

   typedef enum logic [1:0] {
      ACT_PASS = 2'b00,
      ACT_INSERT = 2'b01,
      ACT_STRIP = 2'b10,
      ACT_REPLACE = 2'b11
   } vdte_act_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_INS = 2'b01,
      ST_FCS = 2'b10
   } vdte_state_type;

   typedef struct packed {
      logic [11:0] vid;
      logic [2:0] tsel;
      logic [2:0] prio;
      vdte_role_type role;
   } vdte_port_cfg_type;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } vdte_in_beat_type;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic abort;
   } vdte_out_beat_type;
endpackage

// ==== src/vdte_crc_step.sv ====
// one byte step of the reflected ethernet crc
`timescale 1ns/10ps
`default_nettype none
module vdte_crc_step (
   // running value in
   input wire logic [31:0] crc_i,
   input wire logic [7:0] data_i,
   // running value out
   output logic [31:0] crc_o
);
   import vdte_pkg::*;

   // shift eight bits, lsb first, as they go on the wire
   always_comb begin
      logic [31:0] c;
      c = crc_i ^ {24'h000000, data_i};
      for (int b = 0; b < 8; b++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      crc_o = c;
   end
endmodule // vdte_crc_step
`default_nettype wire

// ==== src/vdte_engine.sv ====
// per-port vlan stacking engine: tag insert, replace, strip and fcs
`timescale 1ns/10ps
`default_nettype none
module vdte_engine #(
   parameter int NUM_PORTS = vdte_pkg::NUM_PORTS
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // ingress stream, ports sampled with the first byte
   input wire logic in_valid_i,
   input wire vdte_pkg::vdte_in_beat_type in_beat_i,
   input wire logic [vdte_pkg::PORT_W-1:0] in_src_port_i,
   input wire logic [vdte_pkg::PORT_W-1:0] in_dst_port_i,
   output logic in_ready_o,
   // egress stream
   output logic out_valid_o,
   output vdte_pkg::vdte_out_beat_type out_beat_o,
   output logic [11:0] out_vid_o
);
   import vdte_pkg::*;

   // table slots need only enough bits to reach the last entry
   localparam int TSEL_W = $clog2(TPID_ENTRIES);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      vdte_state_type st;
      logic [15:0] cnt;
      logic [3:0][7:0] dly;
      logic [2:0] dfill;
      vdte_act_type act;
      logic [3:0][7:0] tag;
      logic [1:0] icnt;
      logic [31:0] crc;
      logic rdy;
      logic ovalid;
      vdte_out_beat_type obeat;
      logic [11:0] fvid;
      logic [PORT_W-1:0] src;
      logic [PORT_W-1:0] dst;
      logic [7:0] hi;
      logic [7:0] tci_hi;
      logic tag1;
      logic abrt;
      logic en;
      logic [15:0] aborts;
      logic [31:0] rdata;
      logic [TPID_ENTRIES-1:0][15:0] tpid;
      vdte_port_cfg_type [NUM_PORTS-1:0] cfg;
   } vdte_st_type;

   vdte_st_type s_reg;
   vdte_st_type s_next;
   logic [31:0] crc_upd;
   logic [7:0] ebyte;
   logic [15:0] cmp_word;
   logic [TPID_ENTRIES-1:0] tpid_hit;
   logic is_tag;
   vdte_role_type src_role;
   vdte_role_type dst_role;
   logic [15:0] out_type;
   logic [7:0] off_t;
   logic [7:0] off_p;
   logic [5:0] idx_t;
   logic [5:0] idx_p;
   logic hit_t;
   logic hit_p;
   logic [TSEL_W-1:0] slot_t;
   logic [PORT_W-1:0] slot_p;

   // ****************************************************************
   // tag recognition
   // ****************************************************************
   // the type word is the held high byte and the byte on the input
   assign cmp_word = {s_reg.hi, in_beat_i.data};

   // one comparator per table entry
   genvar gi;
   generate
      for (gi = 0; gi < TPID_ENTRIES; gi++) begin : g_tpid
         assign tpid_hit[gi] = (s_reg.tpid[gi] == cmp_word);
      end
   endgenerate

   assign is_tag = (cmp_word == TPID_DOT1Q) || (|tpid_hit);

   // roles only apply while stacking is on; otherwise all ports normal
   assign src_role = s_reg.en ? s_reg.cfg[s_reg.src].role : ROLE_NORMAL;
   assign dst_role = s_reg.en ? s_reg.cfg[s_reg.dst].role : ROLE_NORMAL;

   // outer type comes from the egress port's table slot
   // a slot past the table end falls back to slot 0 instead of reading x
   always_comb begin
      if (int'(s_reg.cfg[s_reg.dst].tsel) < TPID_ENTRIES) begin
         out_type = s_reg.tpid[s_reg.cfg[s_reg.dst].tsel];
      end else begin
         out_type = s_reg.tpid[0];
      end
   end

   // ****************************************************************
   // register decode
   // ****************************************************************
   assign off_t = reg_addr_i - REG_TPID_BASE;
   assign off_p = reg_addr_i - REG_PORT_BASE;
   assign idx_t = off_t[7:2];
   assign idx_p = off_p[7:2];
   assign hit_t = (reg_addr_i >= REG_TPID_BASE) && (off_t[1:0] == 2'h0)
      && (int'(idx_t) < TPID_ENTRIES);
   assign hit_p = (reg_addr_i >= REG_PORT_BASE) && (off_p[1:0] == 2'h0)
      && (int'(idx_p) < NUM_PORTS);

   // narrow indexes; the hit terms already bound them to the tables
   assign slot_t = idx_t[TSEL_W-1:0];
   assign slot_p = idx_p[PORT_W-1:0];

   // ****************************************************************
   // fcs
   // ****************************************************************
   vdte_crc_step u_crc (
      .crc_i(s_reg.crc),
      .data_i(ebyte),
      .crc_o(crc_upd)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic emit;
      logic [15:0] tci;
      logic [15:0] own_tci;
      logic [31:0] fcs;
      emit = 1'b0;
      ebyte = 8'h00;
      tci = {s_reg.tci_hi, in_beat_i.data};
      own_tci = {s_reg.cfg[s_reg.src].prio, 1'b0,
         s_reg.cfg[s_reg.src].vid};
      fcs = s_reg.crc ^ CRC_XOR_OUT;
      s_next = s_reg;
      s_next.ovalid = 1'b0;
      s_next.obeat = '0;
      s_next.rdata = 32'h00000000;

      // register writes; slot 0 of the table stays the 802.1q type
      // config is read live at the tag decision: rewrite between frames
      if (reg_wr_i) begin
         if (reg_addr_i == REG_CTRL) begin
            s_next.en = reg_wdata_i[CTRL_EN_BIT];
         end else if (hit_t && (idx_t != 6'h00)) begin
            s_next.tpid[slot_t] = reg_wdata_i[15:0];
         end else if (hit_p) begin
            s_next.cfg[slot_p] =
               vdte_port_cfg_type'(reg_wdata_i[PCFG_W-1:0]);
         end
      end

      // register reads answer the next cycle only; unmapped reads zero
      if (reg_rd_i) begin
         if (reg_addr_i == REG_CTRL) begin
            s_next.rdata = {31'h00000000, s_reg.en};
         end else if (reg_addr_i == REG_ABORTS) begin
            s_next.rdata = {16'h0000, s_reg.aborts};
         end else if (hit_t) begin
            s_next.rdata = {16'h0000, s_reg.tpid[slot_t]};
         end else if (hit_p) begin
            s_next.rdata = {12'h000, s_reg.cfg[slot_p]};
         end
      end

      case (s_reg.st)
         ST_RUN: begin
            if (in_valid_i && s_reg.rdy) begin
               // four-byte delay keeps the old fcs off the wire
               s_next.dly = {s_reg.dly[2:0], in_beat_i.data};
               s_next.cnt = s_reg.cnt + 16'h0001;
               if (s_reg.dfill == DLY_DEPTH) begin
                  // strip and replace swallow old tag bytes 12 to 15 here
                  if (!(((s_reg.act == ACT_STRIP)
                        || (s_reg.act == ACT_REPLACE))
                        && (s_reg.cnt >= IDX_DROP_LO)
                        && (s_reg.cnt <= IDX_DROP_HI))) begin
                     emit = 1'b1;
                     ebyte = s_reg.dly[3];
                  end
               end else begin
                  s_next.dfill = s_reg.dfill + 3'h1;
               end
               if (s_reg.cnt == IDX_FIRST) begin
                  s_next.src = in_src_port_i;
                  s_next.dst = in_dst_port_i;
               end
               if ((s_reg.cnt == IDX_TYPE_HI)
                     || (s_reg.cnt == IDX_TYPE2_HI)) begin
                  s_next.hi = in_beat_i.data;
               end
               if (s_reg.cnt == IDX_TYPE_LO) begin
                  s_next.tag1 = is_tag;
               end
               if (s_reg.cnt == IDX_TCI_HI) begin
                  s_next.tci_hi = in_beat_i.data;
               end
               // second tag behind the first: only tunnel ingress takes it
               if ((s_reg.cnt == IDX_TYPE2_LO) && s_reg.tag1 && is_tag
                     && (src_role != ROLE_TUNNEL)) begin
                  s_next.abrt = 1'b1;
               end
               // decide the edit once the first tag control word is in
               if (s_reg.cnt == IDX_TCI_LO) begin
                  s_next.act = ACT_PASS;
                  s_next.fvid = s_reg.tag1 ? tci[11:0] : 12'h000;
                  s_next.tag = {out_type, own_tci};
                  if (dst_role == ROLE_TUNNEL) begin
                     if ((src_role != ROLE_ACCESS) && s_reg.tag1) begin
                        // keep its vid and priority, retype the outer tag
                        s_next.act = ACT_REPLACE;
                        s_next.tag = {out_type, tci};
                     end else begin
                        // access frames are untagged for stacking purposes
                        s_next.act = ACT_INSERT;
                        s_next.fvid = own_tci[11:0];
                     end
                  end else if ((dst_role == ROLE_ACCESS)
                        && (src_role == ROLE_TUNNEL) && s_reg.tag1) begin
                     s_next.act = ACT_STRIP;
                  end
                  if ((dst_role == ROLE_TUNNEL) && !in_beat_i.last) begin
                     // stall the source while the four tag bytes go out
                     s_next.st = ST_INS;
                     s_next.rdy = 1'b0;
                     s_next.icnt = 2'h0;
                  end
               end
               if (in_beat_i.last) begin
                  s_next.st = ST_FCS;
                  s_next.rdy = 1'b0;
                  s_next.icnt = 2'h0;
               end
            end
         end
         ST_INS: begin
            // outer tag sits between source address and the old tag
            // input waits; the source holds its byte until ready returns
            emit = 1'b1;
            ebyte = s_reg.tag[LAST_BYTE - s_reg.icnt];
            s_next.icnt = s_reg.icnt + 2'h1;
            if (s_reg.icnt == LAST_BYTE) begin
               s_next.st = ST_RUN;
               s_next.rdy = 1'b1;
            end
         end
         ST_FCS: begin
            // fresh fcs, low byte first; old fcs was never sent
            s_next.ovalid = 1'b1;
            s_next.obeat.data = fcs[8*s_reg.icnt +: 8];
            s_next.icnt = s_reg.icnt + 2'h1;
            if (s_reg.icnt == LAST_BYTE) begin
               s_next.obeat.last = 1'b1;
               // bytes already left, so a discard can only be flagged here
               s_next.obeat.abort = s_reg.abrt;
               if (s_reg.abrt) begin
                  s_next.aborts = s_reg.aborts + 16'h0001;
               end
               s_next.st = ST_RUN;
               s_next.rdy = 1'b1;
               s_next.cnt = IDX_FIRST;
               s_next.dfill = 3'h0;
               s_next.crc = CRC_INIT;
               s_next.act = ACT_PASS;
               s_next.tag1 = 1'b0;
               s_next.abrt = 1'b0;
            end
         end
         default: begin
            s_next.st = ST_RUN;
            s_next.rdy = 1'b1;
         end
      endcase

      // every emitted byte feeds the running fcs
      if (emit) begin
         s_next.ovalid = 1'b1;
         s_next.obeat.data = ebyte;
         s_next.crc = crc_upd;
      end

      // synchronous reset: stacking off, table all 802.1q, ports normal
      if (sys_rst_i) begin
         s_next = '0;
         s_next.st = ST_RUN;
         s_next.rdy = 1'b1;
         s_next.crc = CRC_INIT;
         for (int i = 0; i < TPID_ENTRIES; i++) begin
            s_next.tpid[i] = TPID_RST;
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      s_reg <= s_next;
   end

   // outputs straight from the state flops
   assign reg_rdata_o = s_reg.rdata;
   assign in_ready_o = s_reg.rdy;
   assign out_valid_o = s_reg.ovalid;
   assign out_beat_o = s_reg.obeat;
   assign out_vid_o = s_reg.fvid;
endmodule // vdte_engine
`default_nettype wire

// ==== tb/vdte_engine_checker.sv ====
// port assertions for the vlan double tag engine
`timescale 1ns/10ps
`default_nettype none
module vdte_engine_checker #(
   parameter int NUM_PORTS = vdte_pkg::NUM_PORTS
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // byte streams
   input wire logic in_valid_i,
   input wire vdte_pkg::vdte_in_beat_type in_beat_i,
   input wire logic [vdte_pkg::PORT_W-1:0] in_src_port_i,
   input wire logic [vdte_pkg::PORT_W-1:0] in_dst_port_i,
   input wire logic in_ready_o,
   input wire logic out_valid_o,
   input wire vdte_pkg::vdte_out_beat_type out_beat_o,
   input wire logic [11:0] out_vid_o
);
   import vdte_pkg::*;
   logic took;
   // ********
   // helpers
   // ********
   // a byte counts only where valid meets ready
   assign took = in_valid_i && in_ready_o;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // ********
   // assertions
   // ********
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   a_slot0_fixed: assert property (
      reg_rd_i && reg_addr_i == REG_TPID_BASE |=> reg_rdata_o == 32'h8100)
      else $error("tag type slot zero is not 8100");
   a_cfg_narrow: assert property (
      reg_rd_i && reg_addr_i >= REG_PORT_BASE && reg_addr_i < 8'h60
      |=> reg_rdata_o[31:20] == 12'h000)
      else $error("port config reads beyond twenty bits");
   a_abort_narrow: assert property (
      reg_rd_i && reg_addr_i == REG_ABORTS |=> reg_rdata_o[31:16] == 16'h0)
      else $error("abort count wider than sixteen bits");
   a_abort_at_end: assert property (
      out_valid_o && out_beat_o.abort |-> out_beat_o.last)
      else $error("abort flag away from the last byte");
   a_fcs_four: assert property (out_valid_o && out_beat_o.last |->
      $past(out_valid_o, 1) && $past(out_valid_o, 2) && $past(out_valid_o, 3))
      else $error("check sequence not four back to back bytes");
   a_tail_stall: assert property (
      took && in_beat_i.last |=> !in_ready_o [*4] ##1 in_ready_o)
      else $error("ready not low for four cycles after last byte");
   a_tail_fcs: assert property (
      took && in_beat_i.last |-> ##5 (out_valid_o && out_beat_o.last))
      else $error("last output byte not five cycles after last input");
   a_vid_update: assert property (
      !$stable(out_vid_o) |-> $past(took))
      else $error("forwarding vid changed without a taken byte");
endmodule // vdte_engine_checker
bind vdte_engine vdte_engine_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i), .in_beat_i(in_beat_i),
   .in_src_port_i(in_src_port_i), .in_dst_port_i(in_dst_port_i),
   .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
   .out_beat_o(out_beat_o), .out_vid_o(out_vid_o));
`default_nettype wire

// ==== tb/vdte_port_model.sv ====
// network port model: sends one frame and collects the engine output
`timescale 1ns/10ps
`default_nettype none
module vdte_port_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // frame to send
   input wire logic start_i,
   input wire logic [7:0] len_i,
   input wire logic [7:0] frame_i [0:63],
   // engine ingress
   input wire logic in_ready_i,
   output logic in_valid_o,
   output vdte_pkg::vdte_in_beat_type in_beat_o,
   // engine egress
   input wire logic out_valid_i,
   input wire vdte_pkg::vdte_out_beat_type out_beat_i,
   output logic [7:0] got_o [0:79],
   output logic [7:0] got_cnt_o,
   output logic got_abort_o,
   output logic got_end_o
);
   import vdte_pkg::*;
   logic [7:0] idx;
   // sender: a byte is held until taken; released data is inverted so a
   // stale byte can never pass for a fresh one
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         in_valid_o <= 1'b0;
         in_beat_o <= '0;
         idx <= 8'h00;
      end else if (start_i) begin
         in_valid_o <= 1'b1;
         in_beat_o.data <= frame_i[0];
         in_beat_o.last <= 1'b0;
         idx <= 8'h00;
      end else if (in_valid_o && in_ready_i) begin
         if (in_beat_o.last) begin
            in_valid_o <= 1'b0;
            in_beat_o.data <= ~in_beat_o.data;
            in_beat_o.last <= 1'b0;
         end else begin
            in_beat_o.data <= frame_i[idx + 8'h01];
            in_beat_o.last <= (idx + 8'h02 == len_i);
            idx <= idx + 8'h01;
         end
      end
   end
   // receiver: the engine has no back-pressure, so every beat is kept
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || start_i) begin
         got_cnt_o <= 8'h00;
         got_abort_o <= 1'b0;
         got_end_o <= 1'b0;
      end else if (out_valid_i) begin
         got_o[got_cnt_o] <= out_beat_i.data;
         got_cnt_o <= got_cnt_o + 8'h01;
         got_end_o <= out_beat_i.last;
         got_abort_o <= out_beat_i.abort;
      end
   end
endmodule // vdte_port_model
`default_nettype wire

// ==== tb/vdte_engine_bench.sv ====
// self-checking bench for the vlan double tag engine
`timescale 1ns/10ps
`default_nettype none
module vdte_engine_bench;
   import vdte_pkg::*;
   logic ref_clk_i;
   logic sys_rst_i;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [31:0] reg_rdata_o;
   logic in_valid;
   vdte_in_beat_type in_beat;
   logic [PORT_W-1:0] src_port;
   logic [PORT_W-1:0] dst_port;
   logic in_ready;
   logic out_valid;
   vdte_out_beat_type out_beat;
   logic [11:0] out_vid;
   logic start;
   logic [7:0] len;
   logic [7:0] frm [0:63];
   logic [7:0] got [0:79];
   logic [7:0] exp [0:79];
   logic [7:0] got_cnt;
   logic got_abort;
   logic got_end;
   int err_count;
   int cmp_count;
   // ********
   // design and port model
   // ********
   vdte_engine dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .in_valid_i(in_valid), .in_beat_i(in_beat), .in_src_port_i(src_port),
      .in_dst_port_i(dst_port), .in_ready_o(in_ready),
      .out_valid_o(out_valid), .out_beat_o(out_beat), .out_vid_o(out_vid));
   vdte_port_model net (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .start_i(start), .len_i(len), .frame_i(frm), .in_ready_i(in_ready),
      .in_valid_o(in_valid), .in_beat_o(in_beat), .out_valid_i(out_valid),
      .out_beat_i(out_beat), .got_o(got), .got_cnt_o(got_cnt),
      .got_abort_o(got_abort), .got_end_o(got_end));
   // ********
   // tasks
   // ********
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, want, seen);
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // a gap cycle after each write keeps every strobe edge distinct
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge ref_clk_i);
      chk("register read", reg_rdata_o, want);
   endtask
   function automatic logic [31:0] cfg(input logic [11:0] v,
      input logic [2:0] ts, input logic [2:0] p, input vdte_role_type r);
      vdte_port_cfg_type c;
      c = '{vid: v, tsel: ts, prio: p, role: r};
      return {12'h000, c};
   endfunction
   // mode 0 pass, 1 insert ins, 2 strip outer tag, 3 replace tag type
   task automatic run_case(input logic [2:0] s, input logic [2:0] d,
      input int nt, input logic [63:0] tg, input int md,
      input logic [31:0] ins, input logic [11:0] vid, input logic ab);
      int k;
      int n;
      int t;
      logic [31:0] crc;
      k = 12 + 4 * nt;
      for (int i = 0; i < 64; i++) frm[i] = (i < 12) ? 8'(8'h10 + i) : 8'h00;
      for (int i = 0; i < 4 * nt; i++) frm[12 + i] = tg[63 - 8 * i -: 8];
      frm[k] = 8'h08;
      frm[k + 2] = 8'hAA;
      frm[k + 3] = 8'h55;
      len <= 8'(k + 8);
      src_port <= s;
      dst_port <= d;
      start <= 1'b1;
      @(posedge ref_clk_i);
      start <= 1'b0;
      @(posedge ref_clk_i);
      t = 0;
      while (got_end !== 1'b1 && t < 200) begin
         @(posedge ref_clk_i);
         t++;
      end
      if (t == 200) begin
         err_count++;
         wrap_up();
      end
      n = 0;
      for (int i = 0; i < k + 4; i++) begin
         if (md == 1 && i == 12) begin
            for (int j = 0; j < 4; j++) exp[n + j] = ins[31 - 8 * j -: 8];
            n += 4;
         end
         if (md == 3 && (i == 12 || i == 13)) begin
            exp[n] = ins[31 - 8 * (i - 12) -: 8];
            n++;
         end else if (!(md == 2 && i >= 12 && i < 16)) begin
            exp[n] = frm[i];
            n++;
         end
      end
      // reflected crc, so the check sequence goes out low byte first
      crc = CRC_INIT;
      for (int i = 0; i < n; i++) begin
         crc = crc ^ {24'h0, exp[i]};
         for (int b = 0; b < 8; b++) begin
            crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
         end
      end
      crc = crc ^ CRC_XOR_OUT;
      for (int j = 0; j < 4; j++) exp[n + j] = crc[8 * j +: 8];
      n += 4;
      chk("output length", {24'h0, got_cnt}, 32'(n));
      for (int i = 0; i < n; i++) begin
         chk("output byte", {24'h0, got[i]}, {24'h0, exp[i]});
      end
      chk("abort flag", {31'h0, got_abort}, {31'h0, ab});
      if (vid != 12'hFFF) begin
         chk("forwarding vid", {20'h0, out_vid}, {20'h0, vid});
      end
   endtask
   // ********
   // clock, watchdog and main sequence
   // ********
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_count++;
      wrap_up();
   end
   initial begin
      err_count = 0;
      cmp_count = 0;
      sys_rst_i = 1'b1;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      src_port = 3'h0;
      dst_port = 3'h0;
      start = 1'b0;
      len = 8'h00;
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd(REG_CTRL, 32'h0);
      rd(8'h14, 32'h8100);
      wr(REG_TPID_BASE, 32'h1234);
      rd(REG_TPID_BASE, 32'h8100);
      wr(8'h14, 32'h88A8);
      rd(8'h14, 32'h88A8);
      rd(8'h08, 32'h0);
      wr(REG_CTRL, 32'h1);
      wr(8'h44, cfg(12'h0C8, 3'h0, 3'h3, ROLE_ACCESS));
      wr(8'h48, cfg(12'h000, 3'h1, 3'h0, ROLE_TUNNEL));
      wr(8'h4C, cfg(12'h007, 3'h0, 3'h0, ROLE_NORMAL));
      rd(8'h44, cfg(12'h0C8, 3'h0, 3'h3, ROLE_ACCESS));
      run_case(3'h1, 3'h2, 1, 64'h8100201400000000,
         1, 32'h88A860C8, 12'h0C8, 1'b0);
      run_case(3'h3, 3'h2, 0, 64'h0, 1, 32'h88A80007,
         12'h007, 1'b0);
      run_case(3'h3, 3'h2, 1, 64'h8100400900000000,
         3, 32'h88A84009, 12'h009, 1'b0);
      run_case(3'h2, 3'h1, 2, 64'h88A8606481000014,
         2, 32'h0, 12'h064, 1'b0);
      run_case(3'h0, 3'h3, 2, 64'h8100000581000006,
         0, 32'h0, 12'h005, 1'b1);
      run_case(3'h1, 3'h3, 2, 64'h8100000581000006,
         0, 32'h0, 12'h005, 1'b1);
      wr(8'h50, cfg(12'h000, 3'h7, 3'h0, ROLE_TUNNEL));
      run_case(3'h3, 3'h4, 0, 64'h0, 1, 32'h81000007,
         12'h007, 1'b0);
      rd(REG_ABORTS, 32'h2);
      wr(REG_CTRL, 32'h0);
      run_case(3'h1, 3'h2, 1, 64'h8100201400000000,
         0, 32'h0, 12'h014, 1'b0);
      wrap_up();
   end
endmodule // vdte_engine_bench
`default_nettype wire
